/* hdl/rsp_pkg.sv */
package rsp_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [15:0] RSP_ADDR_X = 16'hDF12;
   localparam logic [15:0] RSP_ADDR_Y = 16'hDF13;
   localparam logic [15:0] RSP_ADDR_Z = 16'hDF14;
   localparam logic [15:0] RSP_ADDR_CTRL = 16'hDF15;
   localparam logic [15:0] RSP_ADDR_TMO = 16'hDF16;
   localparam logic [15:0] RSP_ADDR_PWR = 16'hDF17;
   localparam logic [15:0] RSP_ADDR_TCH = 16'hDF20;
   localparam logic [15:0] RSP_ADDR_TCL = 16'hDF21;
   localparam logic [15:0] RSP_ADDR_MAN = 16'hDF22;
   localparam logic [7:0] RSP_RST_ZERO = 8'h00;
   localparam logic [7:0] RSP_RST_PWR = 8'h0C;
   localparam logic [7:0] RSP_RST_TCH = 8'h7A;
   localparam logic [7:0] RSP_RST_TCL = 8'h94;
   localparam logic [7:0] RSP_RST_MAN = 8'hFF;
   localparam logic [7:0] RSP_TMO_OFF = 8'hFF;
   localparam logic [7:0] RSP_TMO_LAST = 8'h01;
   localparam logic [7:0] RSP_Y_MAX = 8'hFF;
   localparam int RSP_CTRL_FLAG = 0;
   localparam int RSP_PWR_PD = 3;
   localparam int RSP_PWR_DLY = 4;
   localparam int RSP_PWR_SEL_HI = 2;
   localparam int RSP_TCH_RX_HI = 7;
   localparam int RSP_TCH_RX_LO = 5;
   localparam int RSP_TCH_SW_HI = 4;
   localparam int RSP_TCH_SW_LO = 2;
   localparam int RSP_TCH_PA_HI = 1;
   localparam int RSP_TCL_PA_HI = 7;
   localparam int RSP_TCL_PA_LO = 6;
   localparam int RSP_TCL_ES_HI = 5;
   localparam int RSP_TCL_ES_LO = 3;
   localparam int RSP_TCL_EP_HI = 2;
   // ****************************************
   // Timing
   // ****************************************
   localparam int RSP_CLK_PERIOD_PS = 25000;
   localparam int RSP_US_PS = 1000000;
   localparam int RSP_CYC_PER_US = RSP_US_PS / RSP_CLK_PERIOD_PS;
   localparam int RSP_RX_STEP_US = 5;
   localparam int RSP_SYMBOL_US = 16;
   localparam int RSP_CAL_HALF_SYMBOLS = 13;
   localparam int RSP_CAL_US = RSP_CAL_HALF_SYMBOLS * RSP_SYMBOL_US / 2;
   localparam logic [10:0] RSP_DLY_US0 = 11'h000;
   localparam logic [10:0] RSP_DLY_US1 = 11'h01F;
   localparam logic [10:0] RSP_DLY_US2 = 11'h03F;
   localparam logic [10:0] RSP_DLY_US3 = 11'h07D;
   localparam logic [10:0] RSP_DLY_US4 = 11'h0FA;
   localparam logic [10:0] RSP_DLY_US5 = 11'h1F4;
   localparam logic [10:0] RSP_DLY_US6 = 11'h3E8;
   localparam logic [10:0] RSP_DLY_US7 = 11'h7D0;
   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic running;
      logic mac_overflow;
      logic inc_y;
      logic dec_y;
      logic inc_max_y;
      logic dec_z;
   } rsp_seq_cmd_t;
   typedef struct packed {
      logic rx_start;
      logic rx_stop;
      logic tx_request;
      logic tx_last_chip;
   } rsp_radio_ev_t;
   typedef struct packed {
      logic gain_peak_reset_n;
      logic global_bias_powerdown;
      logic output_switch_bias_select;
      logic buffer_select;
      logic prescaler_powerdown;
      logic amp_negative_powerdown;
      logic amp_positive_powerdown;
      logic tx_converter_powerdown;
      logic upmix_powerdown;
      logic analog_hold_powerdown;
   } rsp_analog_ctl_t;
   typedef struct packed {
      logic rx_chain_en;
      logic demod_en;
      logic rxtx_switch;
      logic amp_on;
      logic tx_en;
      logic mod_en;
   } rsp_fsm_out_t;
   typedef enum logic [1:0] {
      RSP_RX_IDLE = 2'b00,
      RSP_RX_CAL = 2'b01,
      RSP_RX_CHAIN = 2'b10,
      RSP_RX_ON = 2'b11
   } rsp_rx_state_t;
   typedef enum logic [1:0] {
      RSP_TX_IDLE = 2'b00,
      RSP_TX_LEAD = 2'b01,
      RSP_TX_ON = 2'b10,
      RSP_TX_END = 2'b11
   } rsp_tx_state_t;
   // Power-on delay code to microseconds
   function automatic logic [10:0] rsp_delay_us(input logic [2:0] sel);
      case (sel)
         3'h0: rsp_delay_us = RSP_DLY_US0;
         3'h1: rsp_delay_us = RSP_DLY_US1;
         3'h2: rsp_delay_us = RSP_DLY_US2;
         3'h3: rsp_delay_us = RSP_DLY_US3;
         3'h4: rsp_delay_us = RSP_DLY_US4;
         3'h5: rsp_delay_us = RSP_DLY_US5;
         3'h6: rsp_delay_us = RSP_DLY_US6;
         default: rsp_delay_us = RSP_DLY_US7;
      endcase
   endfunction
endpackage

/* hdl/rsp_regs.sv */
`timescale 1ns/1ps
module rsp_regs
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire rsp_pkg::rsp_seq_cmd_t i_seq,
   input wire rsp_pkg::rsp_radio_ev_t i_ev,
   output logic o_seq_halt,
   output logic [7:0] o_seq_x,
   output logic [7:0] o_seq_y,
   output logic [7:0] o_seq_z,
   output logic o_seq_cpu_flag,
   output logic o_regulator_powerdown,
   output rsp_pkg::rsp_analog_ctl_t o_analog,
   output rsp_pkg::rsp_fsm_out_t o_fsm
);
   // ****************************************
   // Register bus decode
   // ****************************************
   logic [7:0] x_reg, y_reg, z_reg, t_reg;
   logic flag_reg, pd_reg, dly_bit_reg;
   logic [2:0] dsel_reg;
   logic [7:0] tch_reg, tcl_reg, man_reg;
   logic wr_x, wr_y, wr_z, wr_c, wr_t, wr_p, wr_h, wr_l, wr_m;
   assign wr_x = i_wr && (i_addr == rsp_pkg::RSP_ADDR_X);
   assign wr_y = i_wr && (i_addr == rsp_pkg::RSP_ADDR_Y);
   assign wr_z = i_wr && (i_addr == rsp_pkg::RSP_ADDR_Z);
   assign wr_c = i_wr && (i_addr == rsp_pkg::RSP_ADDR_CTRL);
   assign wr_t = i_wr && (i_addr == rsp_pkg::RSP_ADDR_TMO);
   assign wr_p = i_wr && (i_addr == rsp_pkg::RSP_ADDR_PWR);
   assign wr_h = i_wr && (i_addr == rsp_pkg::RSP_ADDR_TCH);
   assign wr_l = i_wr && (i_addr == rsp_pkg::RSP_ADDR_TCL);
   assign wr_m = i_wr && (i_addr == rsp_pkg::RSP_ADDR_MAN);
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
         o_rdata <= rsp_pkg::RSP_RST_ZERO;
      else if (!i_rd)
         o_rdata <= rsp_pkg::RSP_RST_ZERO;
      else
      begin
         // Unmapped addresses and reserved bits read zero
         case (i_addr)
            rsp_pkg::RSP_ADDR_X: o_rdata <= x_reg;
            rsp_pkg::RSP_ADDR_Y: o_rdata <= y_reg;
            rsp_pkg::RSP_ADDR_Z: o_rdata <= z_reg;
            rsp_pkg::RSP_ADDR_CTRL: o_rdata <= {7'h00, flag_reg};
            rsp_pkg::RSP_ADDR_TMO: o_rdata <= t_reg;
            rsp_pkg::RSP_ADDR_PWR:
               o_rdata <= {3'h0, dly_bit_reg, pd_reg, dsel_reg};
            rsp_pkg::RSP_ADDR_TCH: o_rdata <= tch_reg;
            rsp_pkg::RSP_ADDR_TCL: o_rdata <= tcl_reg;
            rsp_pkg::RSP_ADDR_MAN: o_rdata <= man_reg;
            default: o_rdata <= rsp_pkg::RSP_RST_ZERO;
         endcase
      end
   end
   // ****************************************
   // Sequencer operands
   // ****************************************
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
         x_reg <= rsp_pkg::RSP_RST_ZERO;
      else if (wr_x)
         x_reg <= i_wdata;
   end
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
         y_reg <= rsp_pkg::RSP_RST_ZERO;
      else if (wr_y)
         y_reg <= i_wdata;
      else if (i_seq.inc_y)
         y_reg <= y_reg + 8'h01;
      else if (i_seq.dec_y)
         y_reg <= y_reg - 8'h01;
      else if (i_seq.inc_max_y && y_reg != rsp_pkg::RSP_Y_MAX)
         y_reg <= y_reg + 8'h01;
   end
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
         z_reg <= rsp_pkg::RSP_RST_ZERO;
      else if (wr_z)
         z_reg <= i_wdata;
      else if (i_seq.dec_z)
         z_reg <= z_reg - 8'h01;
   end
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
         flag_reg <= 1'b0;
      else if (wr_c)
         flag_reg <= i_wdata[rsp_pkg::RSP_CTRL_FLAG];
   end
   // ****************************************
   // Sequencer timeout
   // ****************************************
   logic tmo_step, tmo_stop;
   assign tmo_step = i_seq.running && i_seq.mac_overflow
      && (t_reg != rsp_pkg::RSP_TMO_OFF);
   assign tmo_stop = tmo_step && (t_reg <= rsp_pkg::RSP_TMO_LAST);

   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
         t_reg <= rsp_pkg::RSP_RST_ZERO;
      else if (wr_t)
         t_reg <= i_wdata;
      else if (tmo_step && !tmo_stop)
         t_reg <= t_reg - 8'h01;
   end
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
         o_seq_halt <= 1'b0;
      else
         o_seq_halt <= tmo_stop && !wr_t;
   end
   assign o_seq_x = x_reg;
   assign o_seq_y = y_reg;
   assign o_seq_z = z_reg;
   assign o_seq_cpu_flag = flag_reg;
   // ****************************************
   // Microsecond tick
   // ****************************************
   logic [5:0] div_reg;
   logic us_tick;
   assign us_tick = (div_reg == 6'(rsp_pkg::RSP_CYC_PER_US - 1));
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
         div_reg <= 6'h00;
      else if (us_tick)
         div_reg <= 6'h00;
      else
         div_reg <= div_reg + 6'h01;
   end
   // ****************************************
   // Regulator power control
   // ****************************************
   logic [10:0] rdly_reg;
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         pd_reg <= rsp_pkg::RSP_RST_PWR[rsp_pkg::RSP_PWR_PD];
         dsel_reg <= rsp_pkg::RSP_RST_PWR[rsp_pkg::RSP_PWR_SEL_HI:0];
      end
      else if (wr_p)
      begin
         pd_reg <= i_wdata[rsp_pkg::RSP_PWR_PD];
         dsel_reg <= i_wdata[rsp_pkg::RSP_PWR_SEL_HI:0];
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         dly_bit_reg <= rsp_pkg::RSP_RST_PWR[rsp_pkg::RSP_PWR_DLY];
         rdly_reg <= 11'h000;
      end
      else if (pd_reg)
      begin
         dly_bit_reg <= 1'b1;
         rdly_reg <= 11'h000;
      end
      else if (dly_bit_reg)
      begin
         // Power-on delay counted in whole microseconds
         if (rdly_reg >= rsp_pkg::rsp_delay_us(dsel_reg))
            dly_bit_reg <= 1'b0;
         else if (us_tick)
            rdly_reg <= rdly_reg + 11'h001;
      end
   end
   assign o_regulator_powerdown = pd_reg;
   // ****************************************
   // Timing and manual mask registers
   // ****************************************
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         tch_reg <= rsp_pkg::RSP_RST_TCH;
         tcl_reg <= rsp_pkg::RSP_RST_TCL;
         man_reg <= rsp_pkg::RSP_RST_MAN;
      end
      else
      begin
         if (wr_h)
            tch_reg <= i_wdata;
         if (wr_l)
            tcl_reg <= i_wdata;
         if (wr_m)
            man_reg <= i_wdata;
      end
   end

   logic [2:0] rx_sel, sw_lead, end_sw, end_pa;
   logic [3:0] pa_lead, lead;
   assign rx_sel = tch_reg[rsp_pkg::RSP_TCH_RX_HI:rsp_pkg::RSP_TCH_RX_LO];
   assign sw_lead = tch_reg[rsp_pkg::RSP_TCH_SW_HI:rsp_pkg::RSP_TCH_SW_LO];
   assign pa_lead = {tch_reg[rsp_pkg::RSP_TCH_PA_HI:0],
      tcl_reg[rsp_pkg::RSP_TCL_PA_HI:rsp_pkg::RSP_TCL_PA_LO]};
   assign end_sw = tcl_reg[rsp_pkg::RSP_TCL_ES_HI:rsp_pkg::RSP_TCL_ES_LO];
   assign end_pa = tcl_reg[rsp_pkg::RSP_TCL_EP_HI:0];
   assign lead = (pa_lead > {1'b0, sw_lead}) ? pa_lead : {1'b0, sw_lead};
   // ****************************************
   // Analog control outputs
   // ****************************************
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
         o_analog <= '1;
      else
      begin
         o_analog.gain_peak_reset_n <= man_reg[7];
         o_analog.output_switch_bias_select <= man_reg[5];
         o_analog.buffer_select <= man_reg[4];
         // Analog held down while the delayed status reads low
         o_analog.analog_hold_powerdown <= !dly_bit_reg;
         o_analog.global_bias_powerdown <= man_reg[6] || !dly_bit_reg;
         o_analog.prescaler_powerdown <= man_reg[3] || !dly_bit_reg;
         o_analog.amp_negative_powerdown <= man_reg[2] || !dly_bit_reg;
         o_analog.amp_positive_powerdown <= man_reg[1] || !dly_bit_reg;
         o_analog.tx_converter_powerdown <= man_reg[0] || !dly_bit_reg;
         o_analog.upmix_powerdown <=
            (man_reg[2] && man_reg[1]) || !dly_bit_reg;
      end
   end
   // ****************************************
   // Receive timing
   // ****************************************
   rsp_pkg::rsp_rx_state_t rx_state;
   logic [7:0] rx_cnt;
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         rx_state <= rsp_pkg::RSP_RX_IDLE;
         rx_cnt <= 8'h00;
      end
      else if (i_ev.rx_stop)
      begin
         rx_state <= rsp_pkg::RSP_RX_IDLE;
         rx_cnt <= 8'h00;
      end
      else
      begin
         unique case (rx_state)
            rsp_pkg::RSP_RX_IDLE:
               if (i_ev.rx_start)
               begin
                  rx_state <= rsp_pkg::RSP_RX_CAL;
                  rx_cnt <= 8'h00;
               end
            rsp_pkg::RSP_RX_CAL:
               if (rx_cnt >= 8'(rsp_pkg::RSP_CAL_US))
               begin
                  rx_state <= rsp_pkg::RSP_RX_CHAIN;
                  rx_cnt <= 8'h00;
               end
               else if (us_tick)
                  rx_cnt <= rx_cnt + 8'h01;
            rsp_pkg::RSP_RX_CHAIN:
               if (rx_cnt >= 8'(rx_sel * rsp_pkg::RSP_RX_STEP_US))
                  rx_state <= rsp_pkg::RSP_RX_ON;
               else if (us_tick)
                  rx_cnt <= rx_cnt + 8'h01;
            rsp_pkg::RSP_RX_ON: ;
         endcase
      end
   end
   // ****************************************
   // Transmit timing
   // ****************************************
   rsp_pkg::rsp_tx_state_t tx_state;
   logic [3:0] tx_cnt;
   logic sw_reg, amp_reg, txen_reg, mod_reg;
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         tx_state <= rsp_pkg::RSP_TX_IDLE;
         tx_cnt <= 4'h0;
         sw_reg <= 1'b0;
         amp_reg <= 1'b0;
         txen_reg <= 1'b0;
         mod_reg <= 1'b0;
      end
      else
      begin
         unique case (tx_state)
            rsp_pkg::RSP_TX_IDLE:
               if (i_ev.tx_request)
               begin
                  tx_state <= rsp_pkg::RSP_TX_LEAD;
                  tx_cnt <= 4'h0;
               end
            rsp_pkg::RSP_TX_LEAD:
            begin
               if (tx_cnt >= lead - {1'b0, sw_lead})
                  sw_reg <= 1'b1;
               if (tx_cnt >= lead - pa_lead)
                  amp_reg <= 1'b1;
               if (tx_cnt >= lead)
               begin
                  tx_state <= rsp_pkg::RSP_TX_ON;
                  txen_reg <= 1'b1;
                  mod_reg <= 1'b1;
               end
               else if (us_tick)
                  tx_cnt <= tx_cnt + 4'h1;
            end
            rsp_pkg::RSP_TX_ON:
               if (i_ev.tx_last_chip)
               begin
                  tx_state <= rsp_pkg::RSP_TX_END;
                  tx_cnt <= 4'h0;
                  txen_reg <= 1'b0;
               end
            rsp_pkg::RSP_TX_END:
            begin
               if (tx_cnt >= {1'b0, end_sw})
                  sw_reg <= 1'b0;
               if (tx_cnt >= {1'b0, end_pa})
               begin
                  amp_reg <= 1'b0;
                  mod_reg <= 1'b0;
               end
               if (tx_cnt >= {1'b0, end_sw} && tx_cnt >= {1'b0, end_pa})
                  tx_state <= rsp_pkg::RSP_TX_IDLE;
               else if (us_tick)
                  tx_cnt <= tx_cnt + 4'h1;
            end
         endcase
      end
   end

   assign o_fsm = {rx_state[1], (rx_state == rsp_pkg::RSP_RX_ON),
      sw_reg, amp_reg, txen_reg, mod_reg};
   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   chk_timeout_count: assert property (
      tmo_step && !tmo_stop && !wr_t |=> t_reg == $past(t_reg) - 8'h01)
      else $error("timeout did not count down");
   chk_timeout_halt: assert property (
      i_seq.running && i_seq.mac_overflow && t_reg == 8'h01 && !wr_t
      |=> o_seq_halt ##1 !o_seq_halt)
      else $error("halt pulse missing");
   chk_timeout_hold: assert property (
      t_reg == 8'hFF && !wr_t |=> t_reg == 8'hFF && !o_seq_halt)
      else $error("all-ones timeout changed");
   chk_x_write: assert property (
      wr_x |=> o_seq_x == $past(i_wdata))
      else $error("X write lost");
   chk_z_decrement: assert property (
      i_seq.dec_z && !wr_z |=> z_reg == $past(z_reg) - 8'h01)
      else $error("Z not decremented");
   chk_ctrl_read: assert property (
      i_rd && i_addr == rsp_pkg::RSP_ADDR_CTRL
      |=> o_rdata == {7'h00, $past(flag_reg)})
      else $error("control read wrong");
   chk_delay_follow: assert property (
      pd_reg |=> dly_bit_reg)
      else $error("delayed bit missed power-down");
   chk_delay_zero: assert property (
      dly_bit_reg && !pd_reg && dsel_reg == 3'h0 && !wr_p |=> !dly_bit_reg)
      else $error("zero delay not immediate");
   chk_analog_hold: assert property (
      !dly_bit_reg |=> o_analog.analog_hold_powerdown
      && o_analog.prescaler_powerdown)
      else $error("analog not held down");
   chk_upmix_down: assert property (
      man_reg[2] && man_reg[1] |=> o_analog.upmix_powerdown)
      else $error("mixers not powered down");
   chk_rx_calib: assert property (
      rx_state == rsp_pkg::RSP_RX_IDLE && i_ev.rx_start && !i_ev.rx_stop
      |=> !o_fsm.rx_chain_en [*8])
      else $error("rx chain before calibration");
   chk_tx_switch: assert property (
      $rose(o_fsm.tx_en) |-> o_fsm.rxtx_switch && o_fsm.amp_on)
      else $error("transmit before switch or amplifier");
   cov_halt: cover property (o_seq_halt);
   cov_rx_on: cover property (o_fsm.demod_en);
   cov_tx_done: cover property (o_fsm.tx_en ##[1:1000] !o_fsm.amp_on);
   cov_reg_up: cover property ($fell(dly_bit_reg));
endmodule

/* verification/rsp_regs_tb.sv */
`timescale 1ns/1ps
module rsp_regs_tb;
   // ****************************************
   // Bench signals
   // ****************************************
   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic [15:0] i_addr = 16'h0000;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   rsp_pkg::rsp_seq_cmd_t i_seq = '0;
   rsp_pkg::rsp_radio_ev_t i_ev = '0;
   logic [7:0] o_rdata, o_seq_x, o_seq_y, o_seq_z;
   logic o_seq_halt, o_seq_cpu_flag, o_regulator_powerdown;
   rsp_pkg::rsp_analog_ctl_t o_analog;
   rsp_pkg::rsp_fsm_out_t o_fsm;
   int num_errors = 0;
   int checked = 0;
   int n;
   logic [7:0] d;
   always #12.5 i_clk = ~i_clk;
   rsp_regs dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_seq(i_seq), .i_ev(i_ev), .o_seq_halt(o_seq_halt),
      .o_seq_x(o_seq_x), .o_seq_y(o_seq_y), .o_seq_z(o_seq_z),
      .o_seq_cpu_flag(o_seq_cpu_flag),
      .o_regulator_powerdown(o_regulator_powerdown),
      .o_analog(o_analog), .o_fsm(o_fsm));
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic stop_test;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk8(input string s, input logic [7:0] e,
                       input logic [7:0] g);
      checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("mismatch %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic chk_rng(input string s, input int lo, input int hi,
                          input int g);
      checked++;
      if (g < lo || g > hi)
      begin
         num_errors++;
         $display("mismatch %s exp %0d..%0d got %0d", s, lo, hi, g);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_clk);
      i_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 v = o_rdata;
   endtask
   // Pulse sequencer commands; the running level is kept afterwards
   task automatic seq(input logic [5:0] c);
      @(posedge i_clk);
      i_seq <= rsp_pkg::rsp_seq_cmd_t'(c);
      @(posedge i_clk);
      i_seq <= rsp_pkg::rsp_seq_cmd_t'(c & 6'h20);
      #1;
   endtask
   task automatic ev(input logic [3:0] e);
      @(posedge i_clk);
      i_ev <= rsp_pkg::rsp_radio_ev_t'(e);
      @(posedge i_clk);
      i_ev <= '0;
      #1;
   endtask
   function automatic logic sig(input int b);
      sig = (b == 6) ? o_analog[0] : o_fsm[b];
   endfunction
   // Bit 6 selects the analog hold, others index the state outputs
   task automatic wt(input int b, input logic v, input int lim);
      while (sig(b) !== v)
      begin
         if (n >= lim)
         begin
            num_errors++;
            $display("mismatch wait %0d exp %b got %b", b, v, sig(b));
            stop_test;
         end
         @(posedge i_clk);
         #1;
         n++;
      end
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      logic [15:0] a[10];
      logic [7:0] e[10];
      a = '{16'hDF12, 16'hDF13, 16'hDF14, 16'hDF15, 16'hDF16, 16'hDF17,
            16'hDF20, 16'hDF21, 16'hDF22, 16'hDF18};
      e = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1C, 8'h7A, 8'h94,
            8'hFF, 8'h00};
      for (int i = 0; i < 10; i++)
      begin
         rd(a[i], d);
         chk8("reset", e[i], d);
      end
   endtask
   task automatic t_rw;
      logic [15:0] a[7];
      logic [7:0] w[7];
      logic [7:0] e[7];
      a = '{16'hDF12, 16'hDF13, 16'hDF14, 16'hDF15, 16'hDF17, 16'hDF18,
            16'hDF22};
      w = '{8'hA5, 8'h5A, 8'hC3, 8'hFF, 8'hFC, 8'hFF, 8'hB6};
      e = '{8'hA5, 8'h5A, 8'hC3, 8'h01, 8'h1C, 8'h00, 8'hB6};
      for (int i = 0; i < 7; i++)
      begin
         wr(a[i], w[i]);
         rd(a[i], d);
         chk8("readback", e[i], d);
      end
      chk8("x", 8'hA5, o_seq_x);
      chk8("flag", 8'h01, {7'h00, o_seq_cpu_flag});
      chk8("pd", 8'h01, {7'h00, o_regulator_powerdown});
      chk8("mask", 8'hB6, o_analog[9:2]);
      chk8("upmix", 8'h02, {6'h00, o_analog[1:0]});
      wr(16'hDF22, 8'h34);
      @(posedge i_clk);
      #1;
      chk8("upmix one", 8'h00, {6'h00, o_analog[1:0]});
   endtask
   task automatic t_yz;
      wr(16'hDF13, 8'hFF);
      seq(6'h08);
      chk8("inc y", 8'h00, o_seq_y);
      seq(6'h04);
      chk8("dec y", 8'hFF, o_seq_y);
      seq(6'h02);
      chk8("max y", 8'hFF, o_seq_y);
      wr(16'hDF13, 8'h10);
      seq(6'h02);
      chk8("max y inc", 8'h11, o_seq_y);
      seq(6'h01);
      chk8("dec z", 8'hC2, o_seq_z);
   endtask
   task automatic t_tmo;
      wr(16'hDF16, 8'h02);
      seq(6'h30);
      chk8("halt early", 8'h00, {7'h00, o_seq_halt});
      seq(6'h30);
      chk8("halt", 8'h01, {7'h00, o_seq_halt});
      @(posedge i_clk);
      #1;
      chk8("halt end", 8'h00, {7'h00, o_seq_halt});
      rd(16'hDF16, d);
      chk8("tmo", 8'h01, d);
      wr(16'hDF16, 8'h05);
      seq(6'h10);
      rd(16'hDF16, d);
      chk8("tmo idle", 8'h05, d);
      wr(16'hDF16, 8'hFF);
      seq(6'h30);
      chk8("no halt", 8'h00, {7'h00, o_seq_halt});
      rd(16'hDF16, d);
      chk8("tmo off", 8'hFF, d);
      seq(6'h00);
   endtask
   task automatic t_pwr;
      wr(16'hDF17, 8'h00);
      n = 0;
      wt(6, 1'b1, 10);
      chk_rng("dly 0", 0, 4, n);
      rd(16'hDF17, d);
      chk8("pwr up", 8'h00, d);
      chk8("held", 8'h7F, o_analog[9:2]);
      chk8("held up", 8'h03, {6'h00, o_analog[1:0]});
      wr(16'hDF17, 8'h10);
      rd(16'hDF17, d);
      chk8("pwr ro", 8'h00, d);
      wr(16'hDF17, 8'hF8);
      rd(16'hDF17, d);
      chk8("pwr down", 8'h18, d);
      n = 0;
      wt(6, 1'b0, 5);
      wr(16'hDF17, 8'h01);
      n = 0;
      wt(6, 1'b1, 1400);
      chk_rng("dly 31", 1198, 1245, n);
      wr(16'hDF17, 8'h0A);
      n = 0;
      wt(6, 1'b0, 5);
      wr(16'hDF17, 8'h02);
      n = 0;
      wt(6, 1'b1, 2600);
      chk_rng("dly 63", 2478, 2525, n);
      wr(16'hDF17, 8'h0C);
   endtask
   task automatic t_tx;
      n = 0;
      ev(4'h2);
      wt(2, 1'b1, 1000);
      chk_rng("amp on", 0, 5, n);
      wt(3, 1'b1, 1000);
      chk_rng("switch on", 118, 165, n);
      wt(1, 1'b1, 1000);
      chk_rng("tx on", 358, 405, n);
      chk8("mod on", 8'h01, {7'h00, o_fsm[0]});
      n = 0;
      ev(4'h1);
      wt(1, 1'b0, 3);
      wt(3, 1'b0, 1000);
      chk_rng("switch off", 38, 85, n);
      wt(2, 1'b0, 1000);
      chk_rng("amp off", 118, 165, n);
      chk8("mod off", 8'h00, {7'h00, o_fsm[0]});
   endtask
   task automatic t_rx;
      n = 0;
      ev(4'h8);
      wt(5, 1'b1, 5000);
      chk_rng("rx chain", 4118, 4165, n);
      n = 0;
      wt(4, 1'b1, 1000);
      chk_rng("demod", 558, 605, n);
      n = 0;
      ev(4'h4);
      wt(5, 1'b0, 5);
      chk8("demod off", 8'h00, {7'h00, o_fsm[4]});
   endtask
   initial
   begin
      repeat (2) @(posedge i_clk);
      i_rstn <= 1'b1;
      repeat (3) @(posedge i_clk);
      t_reset;
      t_rw;
      t_yz;
      t_tmo;
      t_pwr;
      t_tx;
      t_rx;
      stop_test;
   end
endmodule
